// ===== rtl/tfg_top.v
// tone generator: keypad dual tone, alerting tone and 1200 bit/s fsk on one pin
// assumes register port strobes synchronous to mclk, pin driver outside
//
// Chosen here: the strobed register port.
`include "tfg_regs.vh"

// Function
// - dual tone off leaves pin tristated
// - alerting enable gates pin, clear tristates
// - dual enable outputs the enabled low and high tones
// - two-bit selects pick row and column tones
// - high/low enables pick alerting tone set
// - tone steps derived from sample rate
// - fsk shares the same output pin
// - fsk sends 1200 bits per second
// - standard bit picks tone pair
// - transmit enable sets sending, starts bit clock
// - sending latches data bit0 each tick
// - sending cleared, next tick ends transmit
// - flag set each tick while enabled
// - clearing enable stops output at once
// - amplitude bits set fsk level
// - same level for alerting, upper louder
// - fsk registers reset to zero
module tfg_top #(
   parameter BIT_CYC = `TFG_MCLK_HZ / `TFG_BAUD_HZ
)(
   input wire mclk,
   input wire arst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire irq_ack,
   output wire fsk_irq,
   output reg [8:0] tone_out,
   output reg tone_oe_n
);

   localparam SMP_DIV = `TFG_MCLK_HZ / `TFG_SMP_HZ;
   localparam [31:0] SMP_LAST_W = SMP_DIV - 1;
   localparam [31:0] BIT_LAST_W = BIT_CYC - 1;
   // counters are cut on purpose: both terminal counts fit their widths
   localparam [7:0] SMP_LAST = SMP_LAST_W[7:0];
   localparam [17:0] BIT_LAST = BIT_LAST_W[17:0];

   reg [7:0] tone_gen_ctrl_r;
   reg fsk_tx_on_r;
   reg fsk_std_sel_r;
   reg fsk_sending_r;
   reg [1:0] amp_sel_r;
   reg fsk_tx_data_r;
   reg fsk_bit_tick_flag_r;
   reg tx_bit_r;
   reg [7:0] smp_cnt_r;
   reg [17:0] bit_cnt_r;
   reg [23:0] ph_r [0:1];
   reg [23:0] inc_nxt [0:1];
   reg [8:0] smp_nxt;
   reg oe_n_nxt;
   reg [7:0] rdata_nxt;

   wire wr_tone = reg_wr && (reg_addr == `TFG_ADDR_TONE);
   wire wr_fctl = reg_wr && (reg_addr == `TFG_ADDR_FCTL);
   wire wr_fdat = reg_wr && (reg_addr == `TFG_ADDR_FDAT);
   wire wr_fflg = reg_wr && (reg_addr == `TFG_ADDR_FFLG);
   wire smp_tick = (smp_cnt_r == SMP_LAST);
   wire bit_tick = fsk_tx_on_r && (bit_cnt_r == BIT_LAST);
   wire alert_on = tone_gen_ctrl_r[`TFG_ALERT_ON];
   wire dual_on = tone_gen_ctrl_r[`TFG_DUAL_ON];
   wire high_on = tone_gen_ctrl_r[`TFG_HIGH_ON];
   wire low_on = tone_gen_ctrl_r[`TFG_LOW_ON];
   wire [1:0] lsel = tone_gen_ctrl_r[`TFG_LSEL_HI:`TFG_LSEL_LO];
   wire [1:0] usel = tone_gen_ctrl_r[`TFG_USEL_HI:`TFG_USEL_LO];
   wire tx_rise = wr_fctl && reg_wdata[`TFG_TX_ON] && !fsk_tx_on_r;

   // row tone steps
   function [23:0] low_inc;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: low_inc = `TFG_INC_697;
            2'h1: low_inc = `TFG_INC_770;
            2'h2: low_inc = `TFG_INC_852;
            default: low_inc = `TFG_INC_941;
         endcase
      end
   endfunction

   // column tone steps
   function [23:0] high_inc;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: high_inc = `TFG_INC_1209;
            2'h1: high_inc = `TFG_INC_1336;
            2'h2: high_inc = `TFG_INC_1477;
            default: high_inc = `TFG_INC_1633;
         endcase
      end
   endfunction

   // triangle from the top phase bits, 7-bit
   function [6:0] tri_wave;
      input [23:0] ph;
      begin
         tri_wave = ph[23] ? ~ph[22:16] : ph[22:16];
      end
   endfunction

   // scale by level factor in sixteenths
   function [8:0] scale;
      input [8:0] x;
      input [1:0] lvl;
      reg [4:0] f;
      reg [13:0] p;
      begin
         f = `TFG_LVL_0;
         p = 14'h0000;
         case (lvl)
            2'h0: f = `TFG_LVL_0;
            2'h1: f = `TFG_LVL_1;
            2'h2: f = `TFG_LVL_2;
            default: f = `TFG_LVL_3;
         endcase
         p = x * f;
         scale = p[12:4];
      end
   endfunction

   // oscillator 0: row / lower alerting / fsk; oscillator 1: column / upper
   // the fsk carrier reuses oscillator 0, so fsk and row tones never overlap
   always @*
   begin
      if (fsk_tx_on_r)
      begin
         if (fsk_std_sel_r)
         begin
            inc_nxt[0] = tx_bit_r ? `TFG_INC_NA_MARK : `TFG_INC_NA_SPACE;
         end
         else
         begin
            inc_nxt[0] = tx_bit_r ? `TFG_INC_V23_MARK : `TFG_INC_V23_SPACE;
         end
      end
      else if (alert_on)
      begin
         inc_nxt[0] = `TFG_INC_2130;
      end
      else
      begin
         inc_nxt[0] = low_inc(lsel);
      end
      if (alert_on)
      begin
         inc_nxt[1] = `TFG_INC_2750;
      end
      else
      begin
         inc_nxt[1] = high_inc(usel);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_osc
         always @(posedge mclk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               ph_r[gi] <= 24'h000000;
            end
            else if (smp_tick)
            begin
               // free-running phase: a new step takes effect without a click
               ph_r[gi] <= ph_r[gi] + inc_nxt[gi];
            end
         end
      end
   endgenerate

   // output selection, one source only
   always @*
   begin : p_mix
      reg [6:0] w0;
      reg [6:0] w1;
      reg [8:0] lo_part;
      reg [8:0] hi_part;
      w0 = tri_wave(ph_r[0]);
      w1 = tri_wave(ph_r[1]);
      lo_part = low_on ? {2'h0, w0} : 9'h000;
      // upper alerting tone about 2 dB above the lower one
      hi_part = high_on ? ({2'h0, w1} + {4'h0, w1[6:2]}) : 9'h000;
      smp_nxt = 9'h000;
      oe_n_nxt = 1'b1;
      if (fsk_tx_on_r)
      begin
         smp_nxt = scale({2'h0, w0}, amp_sel_r);
         oe_n_nxt = 1'b0;
      end
      else if (alert_on)
      begin
         smp_nxt = scale(lo_part + hi_part, amp_sel_r);
         oe_n_nxt = 1'b0;
      end
      else if (dual_on)
      begin
         smp_nxt = lo_part + (high_on ? {2'h0, w1} : 9'h000);
         oe_n_nxt = 1'b0;
      end
   end

   // pin drive; enable follows at once so a cleared source stops now
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tone_out <= 9'h000;
         tone_oe_n <= 1'b1;
      end
      else
      begin
         tone_oe_n <= oe_n_nxt;
         if (oe_n_nxt)
         begin
            // released pin shows zero so a later enable starts clean
            tone_out <= 9'h000;
         end
         else if (smp_tick)
         begin
            tone_out <= smp_nxt;
         end
      end
   end

   // sample strobe, 1 MHz from the core clock
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         smp_cnt_r <= 8'h00;
      end
      else if (smp_tick)
      begin
         smp_cnt_r <= 8'h00;
      end
      else
      begin
         smp_cnt_r <= smp_cnt_r + 8'h01;
      end
   end

   // bit clock counts only while transmit is on
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_cnt_r <= 18'h00000;
      end
      else if (tx_rise || !fsk_tx_on_r || bit_tick)
      begin
         bit_cnt_r <= 18'h00000;
      end
      else
      begin
         bit_cnt_r <= bit_cnt_r + 18'h00001;
      end
   end

   // register writes and transmit sequencing; a control write beats a same-cycle tick
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tone_gen_ctrl_r <= `TFG_TONE_RST;
         fsk_tx_on_r <= 1'b0;
         fsk_std_sel_r <= 1'b0;
         fsk_sending_r <= 1'b0;
         amp_sel_r <= 2'h0;
         fsk_tx_data_r <= 1'b0;
         tx_bit_r <= 1'b1;
      end
      else
      begin
         if (wr_tone)
         begin
            tone_gen_ctrl_r <= reg_wdata;
         end
         if (wr_fdat)
         begin
            // only the lowest bit is kept, the rest reads back zero
            fsk_tx_data_r <= reg_wdata[0];
         end
         if (wr_fctl)
         begin
            fsk_tx_on_r <= reg_wdata[`TFG_TX_ON];
            fsk_std_sel_r <= reg_wdata[`TFG_STD_SEL];
            amp_sel_r <= reg_wdata[`TFG_AMP_HI:`TFG_AMP_LO];
            if (tx_rise)
            begin
               fsk_sending_r <= 1'b1;
               tx_bit_r <= 1'b1;
            end
            else
            begin
               // software may only clear sending, never set it
               fsk_sending_r <= fsk_sending_r & reg_wdata[`TFG_SENDING] & reg_wdata[`TFG_TX_ON];
            end
         end
         else if (bit_tick)
         begin
            if (fsk_sending_r)
            begin
               tx_bit_r <= fsk_tx_data_r;
            end
            else
            begin
               fsk_tx_on_r <= 1'b0;
               fsk_sending_r <= 1'b0;
            end
         end
      end
   end

   // tick flag: set wins over write-1-clear and acknowledge
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fsk_bit_tick_flag_r <= 1'b0;
      end
      else if (bit_tick)
      begin
         // a lost clear only repeats the request, a lost set would drop a bit
         fsk_bit_tick_flag_r <= 1'b1;
      end
      else if (irq_ack || (wr_fflg && reg_wdata[`TFG_FLAG_BIT]))
      begin
         fsk_bit_tick_flag_r <= 1'b0;
      end
   end

   assign fsk_irq = fsk_bit_tick_flag_r;

   // read mux; bits 4:2 of the fsk control word are unused and read zero
   always @*
   begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `TFG_ADDR_TONE: rdata_nxt = tone_gen_ctrl_r;
         `TFG_ADDR_FCTL: rdata_nxt = {fsk_tx_on_r, fsk_std_sel_r, fsk_sending_r, 3'h0, amp_sel_r};
         `TFG_ADDR_FDAT: rdata_nxt = {7'h00, fsk_tx_data_r};
         `TFG_ADDR_FFLG: rdata_nxt = {7'h00, fsk_bit_tick_flag_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd)
      begin
         reg_rdata <= rdata_nxt;
      end
      else
      begin
         // zero outside the read slot keeps a shared bus or-able
         reg_rdata <= 8'h00;
      end
   end

endmodule

// ===== pkg/tfg_regs.vh
// register map, field positions, rates and phase steps of the tone/fsk generator
// assumes a 250 MHz core clock and 8-bit register port
`ifndef TFG_REGS_VH
`define TFG_REGS_VH

// register addresses
`define TFG_ADDR_TONE 8'hba
`define TFG_ADDR_FCTL 8'hc6
`define TFG_ADDR_FDAT 8'hc7
`define TFG_ADDR_FFLG 8'hc8

// reset values
`define TFG_TONE_RST 8'h00
`define TFG_FCTL_RST 8'h00
`define TFG_FDAT_RST 8'h00

// tone control fields
`define TFG_ALERT_ON 7
`define TFG_DUAL_ON 6
`define TFG_HIGH_ON 5
`define TFG_LOW_ON 4
`define TFG_LSEL_HI 3
`define TFG_LSEL_LO 2
`define TFG_USEL_HI 1
`define TFG_USEL_LO 0

// fsk control fields
`define TFG_TX_ON 7
`define TFG_STD_SEL 6
`define TFG_SENDING 5
`define TFG_AMP_HI 1
`define TFG_AMP_LO 0
`define TFG_FLAG_BIT 0

// timing
`define TFG_MCLK_HZ 250000000
`define TFG_SMP_HZ 1000000
`define TFG_BAUD_HZ 1200

// phase steps, 24-bit accumulator at 1 MHz sample rate
`define TFG_INC_697 24'h002dae
`define TFG_INC_770 24'h003277
`define TFG_INC_852 24'h0037d6
`define TFG_INC_941 24'h003dab
`define TFG_INC_1209 24'h004f3c
`define TFG_INC_1336 24'h00578e
`define TFG_INC_1477 24'h0060cc
`define TFG_INC_1633 24'h006b05
`define TFG_INC_2130 24'h008b98
`define TFG_INC_2750 24'h00b439
`define TFG_INC_V23_MARK 24'h005532
`define TFG_INC_V23_SPACE 24'h0089a0
`define TFG_INC_NA_MARK 24'h004ea5
`define TFG_INC_NA_SPACE 24'h00902e

// level factors in sixteenths: 150, 125, 100, 75 mV
`define TFG_LVL_0 5'h10
`define TFG_LVL_1 5'h0d
`define TFG_LVL_2 5'h0b
`define TFG_LVL_3 5'h08

`endif

// ===== testbench/tfg_line.sv
// far-side model: the line path fed from the shared tone pin
// assumes tone_out is sampled on mclk while tone_oe_n is low
module tfg_line (
   input wire mclk,
   input wire [8:0] tone_out,
   input wire tone_oe_n,
   output logic [8:0] line_lvl,
   output logic [31:0] line_chg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] last_r = 9'h000;
   initial line_chg = 0;
   initial line_lvl = 9'h000;
   // released pin floats, so toggle rather than hold a stale level
   always @(posedge mclk)
   begin
      if (!tone_oe_n)
      begin
         if (tone_out != last_r)
            line_chg <= line_chg + 1;
         last_r <= tone_out;
         line_lvl <= tone_out;
      end
      else
         line_lvl <= ~line_lvl;
   end
endmodule

// ===== testbench/tfg_top_sva.sv
// checker for the tone/fsk generator ports
// assumes one clock domain and the register map of the design
module tfg_top_chk #(
   parameter BIT_CYC = 40
)(
   input wire mclk,
   input wire arst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire irq_ack,
   input wire fsk_irq,
   input wire [8:0] tone_out,
   input wire tone_oe_n
);
   logic [7:0] tone_r;
   logic fon_r;
   logic [31:0] cnt_r;
   wire wr_t = reg_wr && reg_addr == 8'hba;
   wire wr_f = reg_wr && reg_addr == 8'hc6;
   // fon_r goes stale after a hardware stop, which only weakens the checks
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tone_r <= 8'h00;
         fon_r <= 1'b0;
         cnt_r <= 32'h0;
      end
      else
      begin
         if (wr_t)
            tone_r <= reg_wdata;
         if (wr_f)
            fon_r <= reg_wdata[7];
         if (wr_f && reg_wdata[7] && !fon_r)
            cnt_r <= 32'h0;
         else if (cnt_r != 32'hffffffff)
            cnt_r <= cnt_r + 1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property ($past(reg_rd) && !($past(reg_addr) inside {8'hba, 8'hc6, 8'hc7, 8'hc8})
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   data_bit_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hc7 |-> reg_rdata[7:1] == 7'h00)
      else $error("data register upper bits read");
   idle_zero_a: assert property (tone_oe_n |-> tone_out == 9'h000)
      else $error("sample while released");
   fsk_start_a: assert property (wr_f && reg_wdata[7] |-> ##2 !tone_oe_n)
      else $error("fsk did not drive pin");
   fsk_stop_a: assert property (wr_f && !reg_wdata[7] && tone_r[7:6] == 2'b00 |-> ##2 tone_oe_n)
      else $error("fsk did not stop at once");
   tone_on_a: assert property (wr_t && reg_wdata[7:6] != 2'b00 |-> ##[1:3] !tone_oe_n)
      else $error("tone did not drive pin");
   tone_off_a: assert property (wr_t && reg_wdata[7:6] == 2'b00 && !fon_r |-> ##[1:3] tone_oe_n)
      else $error("pin not released");
   irq_hold_a: assert property (fsk_irq && !irq_ack && !(reg_wr && reg_addr == 8'hc8 && reg_wdata[0])
      |=> fsk_irq) else $error("flag dropped by itself");
   tick_early_a: assert property ($rose(fsk_irq) |-> cnt_r >= BIT_CYC - 1)
      else $error("bit tick too early");
endmodule
bind tfg_top tfg_top_chk #(.BIT_CYC(BIT_CYC)) u_tfg_top_chk (.mclk(mclk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq_ack(irq_ack), .fsk_irq(fsk_irq), .tone_out(tone_out), .tone_oe_n(tone_oe_n));

// ===== testbench/tfg_top_bench.sv
// self-checking bench for the tone/fsk generator
// assumes a short bit period parameter so ticks come every 40 cycles
module tfg_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam BIT = 40;
   logic mclk = 0;
   logic arst_n = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic irq_ack = 0;
   wire [7:0] reg_rdata;
   wire fsk_irq;
   wire [8:0] tone_out;
   wire tone_oe_n;
   wire [8:0] line_lvl;
   wire [31:0] line_chg;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'h1df1;
   logic [7:0] d;
   logic [31:0] n0;
   always #2 mclk = ~mclk;
   tfg_top #(.BIT_CYC(BIT)) u_tfg_top (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
      .fsk_irq(fsk_irq), .tone_out(tone_out), .tone_oe_n(tone_oe_n));
   tfg_line u_tfg_line (.mclk(mclk), .tone_out(tone_out), .tone_oe_n(tone_oe_n), .line_lvl(line_lvl),
      .line_chg(line_chg));
   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // unused bits 4:2 read zero, sending shows in bit 5
   function logic [8:0] ctl_exp(input logic [7:0] v, input logic snd);
      return {1'b0, v & 8'hc3} | (snd ? 9'h020 : 9'h000);
   endfunction
   task chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1;
      @(posedge mclk);
      reg_wr <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [8:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge mclk);
      reg_rd <= 0;
      #1;
      chk({1'b0, reg_rdata}, exp);
   endtask
   task wait_irq();
      int n;
      n = 0;
      while (fsk_irq !== 1'b1 && n < 3 * BIT)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask
   task clr(input logic by_reg);
      if (by_reg)
         wr(8'hc8, 8'h01);
      else
      begin
         @(posedge mclk);
         irq_ack <= 1;
         @(posedge mclk);
         irq_ack <= 0;
      end
      #1;
      chk(fsk_irq, 0);
   endtask
   task results();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #200000;
      fails++;
      results();
   end
   initial
   begin
      repeat (6) @(posedge mclk);
      arst_n <= 1;
      #1;
      chk(tone_oe_n, 1);
      rd(8'hc6, 0);
      rd(8'hc7, 0);
      wr(8'h55, 8'hff);
      rd(8'h55, 0);
      rd(8'hba, 0);
      wr(8'hc7, 8'hfe);
      rd(8'hc7, 0);
      wr(8'hc7, 8'h03);
      rd(8'hc7, 1);
      $display("test regs done");
      for (int i = 0; i < 6; i++)
      begin
         d = (rnd() & 8'h2f) | 8'h10 | (i[0] ? 8'h80 : 8'h40);
         n0 = line_chg;
         wr(8'hba, d);
         rd(8'hba, d);
         chk(tone_oe_n, 0);
         repeat (3000) @(posedge mclk);
         #1;
         chk(line_chg != n0, 1);
         wr(8'hba, 8'h00);
         @(posedge mclk);
         #1;
         chk(tone_oe_n, 1);
         chk(tone_out, 0);
      end
      $display("test tones done");
      for (int k = 0; k < 2; k++)
      begin
         d = 8'h80 | (rnd() & 8'h43);
         wr(8'hc6, d);
         rd(8'hc6, ctl_exp(d, 1));
         chk(tone_oe_n, 0);
         repeat (3)
         begin
            wr(8'hc7, rnd());
            wait_irq();
            chk(fsk_irq, 1);
            clr(k[0]);
         end
         wr(8'hc6, d);
         wait_irq();
         chk(fsk_irq, 1);
         @(posedge mclk);
         #1;
         chk(tone_oe_n, 1);
         rd(8'hc6, ctl_exp(d, 0) & 9'h043);
         clr(k[0]);
      end
      $display("test fsk done");
      wr(8'hc6, 8'h80);
      repeat (5) @(posedge mclk);
      wr(8'hc6, 8'h00);
      @(posedge mclk);
      #1;
      chk(tone_oe_n, 1);
      $display("test stop done");
      results();
   end
endmodule
